// ---- core/dcds_pkg.sv ----
// What this block does
// [R1] 16-bit count decrements after every transfer
// [R2] stop at zero count if enabled or unsynchronized
// [R3] source/unsynced transfers run back to back
// [R4] destination-synced: no fetch before request
// [R5] destination-synced: release bus two clocks
// [R6] destination peripheral drops request within gap
// [R7] peripheral uses source read as acknowledge
// [R8] higher priority first, equal priority alternates
// [R9] dma beats cpu except locked/odd halves; code defers only on cpu_lock, not odd halves
// [R10] external hold beats pending dma cycle
// [R11] nmi halts dma, maskable interrupts do not
// [R12] run bit enables; synced modes need request
// [R13] software loads pointers before setting run
// [R14] registers writable; run kept without change-enable
// [R15] software uses locked writes for multi-register update
// [R16] reset clears run, aborts transfer
// [R17] reset leaves counters and pointers undefined
// [R18] third timer usable as request source
// [R19] pointer steps one or two; both hold
// [R20] priority bit: 0 low, 1 high
// [R21] timer request enable bit gates timer requests
// [R22] count termination raises interrupt when enabled
//
// Purpose: constants and types of the dual dma sequencer
// Assumes: printed register offsets used as byte addresses
// Notes:   one package shared by the design file and all verif files
package dcds_pkg;

  // register map, channel base plus offset
  localparam logic [7:0] CH0_BASE   = 8'hC0;
  localparam logic [7:0] CH1_BASE   = 8'hD0;
  localparam logic [3:0] OFS_SRC_LO = 4'h0;
  localparam logic [3:0] OFS_SRC_HI = 4'h2;
  localparam logic [3:0] OFS_DST_LO = 4'h4;
  localparam logic [3:0] OFS_DST_HI = 4'h6;
  localparam logic [3:0] OFS_COUNT  = 4'h8;
  localparam logic [3:0] OFS_CTL    = 4'hA;

  // control word field positions
  localparam int CTL_DST_MEM = 15;
  localparam int CTL_DST_DEC = 14;
  localparam int CTL_DST_INC = 13;
  localparam int CTL_SRC_MEM = 12;
  localparam int CTL_SRC_DEC = 11;
  localparam int CTL_SRC_INC = 10;
  localparam int CTL_STOP_EN = 9;
  localparam int CTL_INT_EN  = 8;
  localparam int CTL_SYNC_LO = 6;
  localparam int CTL_PRIO    = 5;
  localparam int CTL_TMR_EN  = 4;
  localparam int CTL_RUN_WE  = 2;
  localparam int CTL_RUN     = 1;
  localparam int CTL_WORD    = 0;
  // stored bits: run_write_enable, run and bit 3 excluded
  localparam logic [15:0] CTL_STORE_MASK = 16'hFFF1;

  // synchronisation field codes
  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_SRC  = 2'h1;
  localparam logic [1:0] SYNC_DST  = 2'h2;

  // pointer steps and release gap
  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;
  localparam int          GAP_CLKS  = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_STORE,
    ST_GAP
  } dcds_state_e;

  // local bus request, held until bus_ready
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        mem;
    logic        word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dcds_bus_s;

  // state that reset defines
  typedef struct packed {
    logic [1:0]  run;
    dcds_state_e fsm;
    logic        act;
    logic        last;
    logic [15:0] data;
    dcds_bus_s   bus;
    logic [1:0]  irq;
    logic [15:0] rdata;
  } dcds_ctl_s;

  // channel registers that reset leaves alone
  typedef struct packed {
    logic [1:0][19:0] src;
    logic [1:0][19:0] dst;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] ctl;
  } dcds_data_s;

endpackage

// ---- core/dcds_sequencer.sv ----
// Purpose: two-channel dma sequencer with register port
// Assumes: single 10 MHz clock, inputs synchronous
// Notes:   channel registers carry no reset
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module dcds_sequencer
  import dcds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [1:0]  transfer_request,
  input  wire logic        timer2_request,
  input  wire logic        hold_request,
  input  wire logic        nmi_request,
  input  wire logic        cpu_lock,
  input  wire logic        bus_ready,
  input  wire logic [15:0] bus_rdata,
  output dcds_bus_s        bus,
  output logic      [1:0]  done_irq
);

  ////////////////////////////////////////////////////////////
  // state and decode

  dcds_ctl_s   s;
  dcds_ctl_s   next_s;
  dcds_data_s  d;
  dcds_data_s  next_d;

  logic        hit;
  logic        sel;
  logic [3:0]  ofs;
  logic [1:0]  req;
  logic [1:0]  elig;
  logic [1:0]  run_eff;
  logic        cur;
  logic [15:0] cw;
  logic [15:0] cnt_dec;
  logic        store_done;
  logic        stop_now;
  logic        blocked;
  logic        pick;
  logic        pick_ok;
  logic        may_start;

  // address decode of both channel blocks
  assign hit = (addr[7:5] == CH0_BASE[7:5]) && (addr[0] == 1'b0);
  assign sel = (addr[7:4] == CH1_BASE[7:4]);
  assign ofs = addr[3:0];

  // pointer step: by one or two, both or none hold
  function automatic logic [19:0] step_ptr(
    input logic [19:0] ptr,
    input logic        inc,
    input logic        dec,
    input logic        word
  );
    logic [19:0] st;
    st = word ? STEP_WORD : STEP_BYTE;
    if (inc && !dec)
      step_ptr = ptr + st;
    else if (dec && !inc)
      step_ptr = ptr - st;
    else
      step_ptr = ptr;
  endfunction

  ////////////////////////////////////////////////////////////
  // termination and arbitration

  // active channel view, used at store completion
  always_comb
  begin
    cur        = s.act;
    cw         = d.ctl[cur];
    store_done = (s.fsm == ST_STORE) && bus_ready;
    // [R1] count decrement
    // always counted, stop option or not
    cnt_dec    = d.cnt[cur] - 16'h0001;
    // [R2] stop at zero
    // unsynced mode ignores the stop option bit
    stop_now   = (cnt_dec == 16'h0000) &&
                 (cw[CTL_STOP_EN] ||
                  (cw[CTL_SYNC_LO +: 2] == SYNC_NONE));
  end

  // per-channel eligibility
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      // [R18] [R21] timer request gated
      req[c] = transfer_request[c] ||
               (d.ctl[c][CTL_TMR_EN] && timer2_request);
      // a finishing channel must not be relaunched
      run_eff[c] = s.run[c] &&
                   !(store_done && (cur == c[0]) && stop_now);
      // [R12] [R4] run plus request
      // synced modes wait for the request before fetch
      unique case (d.ctl[c][CTL_SYNC_LO +: 2])
        SYNC_NONE:
          elig[c] = run_eff[c];
        SYNC_SRC,
        SYNC_DST:
          elig[c] = run_eff[c] && req[c];
        default:
          elig[c] = 1'b0;
      endcase
    end
  end

  // choose channel and decide whether a cycle may begin
  always_comb
  begin
    // [R10] [R11] [R9] hold, nmi, locked cpu
    // maskable interrupts have no input here on purpose
    blocked = hold_request || nmi_request || cpu_lock;
    pick_ok = |elig && !blocked;
    // [R8] [R20] priority then alternation
    if (elig == 2'b11)
    begin
      if (d.ctl[0][CTL_PRIO] != d.ctl[1][CTL_PRIO])
        pick = d.ctl[1][CTL_PRIO];
      else
        pick = !s.last;
    end
    else
    begin
      pick = elig[1];
    end
    // [R3] back to back start
    // source/unsynced chain straight from the store
    may_start = (s.fsm == ST_IDLE) ||
                (store_done &&
                 (cw[CTL_SYNC_LO +: 2] != SYNC_DST));
  end

  ////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_s       = s;
    next_d       = d;
    next_s.irq   = 2'b00;
    next_s.rdata = 16'h0000;

    // transfer sequence
    unique case (s.fsm)
      ST_IDLE:
      begin
        next_s.bus.valid = 1'b0;
      end
      ST_FETCH:
      begin
        // fetched data launches the store cycle
        if (bus_ready)
        begin
          next_s.data      = bus_rdata;
          next_s.fsm       = ST_STORE;
          next_s.bus.valid = 1'b1;
          next_s.bus.write = 1'b1;
          next_s.bus.mem   = cw[CTL_DST_MEM];
          next_s.bus.word  = cw[CTL_WORD];
          next_s.bus.addr  = d.dst[cur];
          next_s.bus.wdata = bus_rdata;
        end
      end
      ST_STORE:
      begin
        if (bus_ready)
        begin
          next_d.cnt[cur] = cnt_dec;
          // [R19] pointer stepping
          next_d.src[cur] = step_ptr(d.src[cur],
                                     cw[CTL_SRC_INC],
                                     cw[CTL_SRC_DEC],
                                     cw[CTL_WORD]);
          next_d.dst[cur] = step_ptr(d.dst[cur],
                                     cw[CTL_DST_INC],
                                     cw[CTL_DST_DEC],
                                     cw[CTL_WORD]);
          // [R2] clear run at zero
          if (stop_now)
          begin
            next_s.run[cur] = 1'b0;
            // [R22] termination interrupt
            next_s.irq[cur] = cw[CTL_INT_EN];
          end
          next_s.bus.valid = 1'b0;
          next_s.bus.write = 1'b0;
          // [R5] release after dest-synced
          // the gap lets the peripheral drop its request
          if (cw[CTL_SYNC_LO +: 2] == SYNC_DST)
            next_s.fsm = ST_GAP;
          else
            next_s.fsm = ST_IDLE;
        end
      end
      ST_GAP:
      begin
        // second released clock spent in idle
        next_s.fsm = ST_IDLE;
      end
    endcase

    // launch a fetch on the chosen channel
    if (may_start && pick_ok)
    begin
      next_s.fsm       = ST_FETCH;
      next_s.act       = pick;
      next_s.last      = pick;
      next_s.bus.valid = 1'b1;
      next_s.bus.write = 1'b0;
      next_s.bus.mem   = d.ctl[pick][CTL_SRC_MEM];
      next_s.bus.word  = d.ctl[pick][CTL_WORD];
      next_s.bus.addr  = (store_done && (pick == cur)) ?
                         next_d.src[pick] : d.src[pick];
      next_s.bus.wdata = 16'h0000;
    end

    // [R14] register writes while running
    // software write lands after the dma update and wins
    if (wr && hit)
    begin
      unique case (ofs)
        OFS_SRC_LO:
          next_d.src[sel][15:0] = wdata;
        OFS_SRC_HI:
          next_d.src[sel][19:16] = wdata[3:0];
        OFS_DST_LO:
          next_d.dst[sel][15:0] = wdata;
        OFS_DST_HI:
          next_d.dst[sel][19:16] = wdata[3:0];
        OFS_COUNT:
          next_d.cnt[sel] = wdata;
        OFS_CTL:
        begin
          next_d.ctl[sel] = wdata & CTL_STORE_MASK;
          // run only moves with run_write_enable set
          if (wdata[CTL_RUN_WE])
            next_s.run[sel] = wdata[CTL_RUN];
        end
        default:
        begin
        end
      endcase
    end

    // read data for the following cycle only
    if (rd && hit)
    begin
      unique case (ofs)
        OFS_SRC_LO:
          next_s.rdata = d.src[sel][15:0];
        OFS_SRC_HI:
          next_s.rdata = {12'h000, d.src[sel][19:16]};
        OFS_DST_LO:
          next_s.rdata = d.dst[sel][15:0];
        OFS_DST_HI:
          next_s.rdata = {12'h000, d.dst[sel][19:16]};
        OFS_COUNT:
          next_s.rdata = d.cnt[sel];
        OFS_CTL:
        begin
          next_s.rdata          = d.ctl[sel];
          next_s.rdata[CTL_RUN] = s.run[sel];
        end
        default:
          next_s.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // registers

  // [R16] reset stops and aborts
  // bus request dropped, both channels stopped
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // [R17] no reset on channel data
  // counters and pointers keep whatever they held
  always_ff @(posedge clk)
  begin
    d <= next_d;
  end

  // outputs straight from flops
  assign bus      = s.bus;
  assign rdata    = s.rdata;
  assign done_irq = s.irq;

endmodule

// ---- verif/dcds_checker.sv ----
// Purpose: port checks of the sequencer
// Assumes: one clock, async low reset
// Notes:   bound below the module
`timescale 1ns/1ps

module dcds_checker
  import dcds_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        hold_request,
  input wire logic        nmi_request,
  input wire logic        cpu_lock,
  input wire logic        bus_ready,
  input wire logic [15:0] bus_rdata,
  input wire dcds_bus_s   bus,
  input wire logic [1:0]  done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////
  // free: no transfer half-way, so a block must hold the bus idle
  logic free;
  logic done;
  assign free = !bus.valid || (bus.write && bus_ready);
  assign done = bus.valid && bus.write && bus_ready;
  ////////////////////////////////
  chk_bus_stands: assert property (bus.valid && !bus_ready |=> $stable(bus))
    else $error("bus moved before ready");
  chk_store_follows: assert property (bus.valid && !bus.write && bus_ready
    |=> bus.valid && bus.write && bus.wdata == $past(bus_rdata))
    else $error("store missing after fetch");
  chk_hold_blocks: assert property (hold_request && free |=> !bus.valid)
    else $error("dma started under hold");
  chk_nmi_blocks: assert property (nmi_request && free |=> !bus.valid)
    else $error("dma started under nmi");
  chk_lock_blocks: assert property (cpu_lock && free |=> !bus.valid)
    else $error("dma started under lock");
  chk_gap_two: assert property (done ##1 !bus.valid |=> !bus.valid)
    else $error("release gap too short");
  chk_irq_cause: assert property (done_irq != 2'h0 |-> $past(done))
    else $error("irq without store");
  chk_reset_quiet: assert property ($rose(resetn) |-> !bus.valid && done_irq == 2'h0)
    else $error("activity after reset");
  chk_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside slot");
  cover property ($rose(bus.valid));
  cover property (done_irq != 2'h0);
  cover property (done ##1 !bus.valid ##1 !bus.valid ##1 bus.valid);
endmodule

bind dcds_sequencer dcds_checker dcds_checker_i (.clk(clk), .resetn(resetn), .rd(rd),
  .rdata(rdata), .hold_request(hold_request), .nmi_request(nmi_request),
  .cpu_lock(cpu_lock), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus(bus),
  .done_irq(done_irq));

// ---- verif/dcds_bus_model.sv ----
// Purpose: memory and io answering the local bus
// Assumes: one access at a time
// Notes:   slow adds one wait state
`timescale 1ns/1ps

module dcds_bus_model
  import dcds_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire dcds_bus_s bus,
  input  wire logic      slow,
  output logic           bus_ready,
  output logic [15:0]    bus_rdata
);
  logic        waited;
  logic [15:0] word;
  assign bus_ready = bus.valid && (!slow || waited);
  // data only in the answer, inverse otherwise
  assign word      = bus.addr[15:0] ^ 16'h5A5A;
  assign bus_rdata = (bus_ready && !bus.write) ? word : ~word;
  // wait state tracker
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      waited <= 1'b0;
    else
      waited <= bus.valid && !bus_ready;
endmodule

// ---- verif/dcds_sequencer_bench.sv ----
// Purpose: directed regression of the sequencer
// Assumes: bus model answers every access
// Notes:   stores are logged, judged per scenario
`timescale 1ns/1ps

module dcds_sequencer_bench;
  import dcds_pkg::*;
  logic        clk;
  logic        resetn;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [1:0]  transfer_request;
  logic        timer2_request;
  logic [2:0]  blk;
  logic        slow;
  logic        bus_ready;
  logic [15:0] bus_rdata;
  dcds_bus_s   bus;
  logic [1:0]  done_irq;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_irq = 0;
  logic [19:0] st_a[$];
  logic [15:0] st_d[$];
  int          st_t[$];
  logic [1:0]  st_m[$];
  logic [1:0]  ft_m[$];

  dcds_sequencer dcds_sequencer_i (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .transfer_request(transfer_request),
    .timer2_request(timer2_request), .hold_request(blk[0]), .nmi_request(blk[1]),
    .cpu_lock(blk[2]), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus(bus),
    .done_irq(done_irq));
  dcds_bus_model dcds_bus_model_i (.clk(clk), .resetn(resetn), .bus(bus), .slow(slow),
    .bus_ready(bus_ready), .bus_rdata(bus_rdata));
  ////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // log stores and irq pulses
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (done_irq != 2'h0)
      n_irq <= n_irq + 1;
    if (bus.valid && bus.write && bus_ready)
    begin
      st_a.push_back(bus.addr);
      st_d.push_back(bus.wdata);
      st_t.push_back(cyc);
      st_m.push_back({bus.mem, bus.word});
    end
    // fetch space and width, judged per scenario
    if (bus.valid && !bus.write && bus_ready)
      ft_m.push_back({bus.mem, bus.word});
  end
  ////////////////////////////////
  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] ra(input bit ch, input logic [3:0] o);
    return (ch ? CH1_BASE : CH0_BASE) | {4'h0, o};
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data land one cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp({4'h0, rdata}, {4'h0, e});
  endtask
  task automatic prog(input bit ch, input logic [15:0] s, d, n, c);
    wreg(ra(ch, OFS_SRC_LO), s);
    wreg(ra(ch, OFS_SRC_HI), 16'h0000);
    wreg(ra(ch, OFS_DST_LO), d);
    wreg(ra(ch, OFS_DST_HI), 16'h0000);
    wreg(ra(ch, OFS_COUNT), n);
    wreg(ra(ch, OFS_CTL), c);
  endtask
  task automatic wait_st(input int n);
    for (int i = 0; i < 400 && st_a.size() < n; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic clr();
    st_a.delete();
    st_d.delete();
    st_t.delete();
    st_m.delete();
    ft_m.delete();
  endtask
  function automatic logic [19:0] nst();
    return 20'(st_a.size());
  endfunction
  ////////////////////////////////
  task automatic t_reset();
    wreg(ra(0, OFS_CTL), 16'h0000);
    rchk(ra(0, OFS_CTL), 16'h0000);
    wreg(ra(0, OFS_CTL), 16'h0002);
    rchk(ra(0, OFS_CTL), 16'h0000);
  endtask
  task automatic t_unsync();
    int i0;
    clr();
    i0 = n_irq;
    prog(0, 16'h0100, 16'h0200, 16'h0003, 16'hB507);
    wait_st(3);
    for (int i = 0; i < 3; i++)
    begin
      cmp(st_a[i], 20'h00200 + 20'(2 * i));
      cmp({4'h0, st_d[i]}, 20'h05A5A ^ (20'h00100 + 20'(2 * i)));
    end
    cmp({18'h00000, st_m[0]}, 20'h00003);
    cmp(20'(st_t[2] - st_t[1]), 20'h00002);
    cmp(20'(n_irq - i0), 20'h00001);
    rchk(ra(0, OFS_COUNT), 16'h0000);
    rchk(ra(0, OFS_CTL), 16'hB501);
    cmp(nst(), 20'h00003);
  endtask
  task automatic t_dst();
    int i0;
    clr();
    i0 = n_irq;
    slow <= 1'b1;
    prog(1, 16'h0300, 16'h0400, 16'h0002, 16'hAE86);
    repeat (10) @(posedge clk);
    cmp(nst(), 20'h00000);
    transfer_request <= 2'h2;
    wait_st(2);
    transfer_request <= 2'h0;
    slow <= 1'b0;
    cmp(st_a[1], 20'h00401);
    cmp({4'h0, st_d[1]}, 20'h0595A);
    cmp({18'h00000, st_m[0]}, 20'h00002);
    cmp({18'h00000, ft_m[0]}, 20'h00000);
    cmp(20'(st_t[1] - st_t[0]), 20'(GAP_CLKS + 4));
    cmp(20'(n_irq - i0), 20'h00000);
    rchk(ra(1, OFS_COUNT), 16'h0000);
  endtask
  task automatic t_block();
    for (int k = 0; k < 3; k++)
    begin
      clr();
      blk <= 3'(1 << k);
      prog(0, 16'h0100, 16'h0200, 16'h0001, 16'hB507);
      repeat (8) @(posedge clk);
      cmp(nst(), 20'h00000);
      blk <= 3'h0;
      wait_st(1);
      cmp(nst(), 20'h00001);
    end
  endtask
  task automatic t_prio(input logic [15:0] c1, input logic [0:3][19:0] e);
    clr();
    // lock keeps transfers out of the updates
    blk <= 3'h4;
    prog(0, 16'h0100, 16'h0200, 16'h0002, 16'hB507);
    prog(1, 16'h0500, 16'h0600, 16'h0002, c1);
    blk <= 3'h0;
    wait_st(4);
    for (int i = 0; i < 4; i++)
      cmp(st_a[i], e[i]);
  endtask
  // dst pointer set to count down by two
  task automatic t_timer();
    clr();
    prog(0, 16'h0100, 16'h0200, 16'h0001, 16'hD657);
    repeat (6) @(posedge clk);
    cmp(nst(), 20'h00000);
    timer2_request <= 1'b1;
    wait_st(1);
    timer2_request <= 1'b0;
    cmp(nst(), 20'h00001);
    rchk(ra(0, OFS_DST_LO), 16'h01FE);
  endtask
  // reset during a fetch: run cleared, data kept
  task automatic t_abort();
    prog(0, 16'h0100, 16'h0200, 16'h0010, 16'hB507);
    slow <= 1'b1;
    for (int i = 0; i < 20 && !bus.valid; i++)
      @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({19'h00000, bus.valid}, 20'h00000);
    resetn <= 1'b1;
    slow <= 1'b0;
    clr();
    repeat (20) @(posedge clk);
    cmp(nst(), 20'h00000);
    rchk(ra(0, OFS_CTL), 16'hB501);
    rchk(ra(0, OFS_SRC_LO), 16'h0100);
  endtask
  ////////////////////////////////
  task automatic close_out();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // run ends near 300 cycles; give it over sixteen times that
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial
  begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    transfer_request = 2'h0;
    timer2_request = 1'b0;
    blk = 3'h0;
    slow = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_unsync();
    t_dst();
    t_block();
    t_prio(16'hB527, {20'h00600, 20'h00602, 20'h00200, 20'h00202});
    t_prio(16'hB507, {20'h00600, 20'h00200, 20'h00602, 20'h00202});
    t_timer();
    t_abort();
    close_out();
  end
endmodule
